// >>> smhp_host_port.sv
// scan master host port: strobe-timed 8-bit register access with ready
`timescale 1ns/1ps
module smhp_host_port #(
  parameter int LEAD_MAX = smhp_pkg::LEAD_LIMIT
) (
  input  wire logic                    mclk_in,            // core clock
  input  wire logic                    rst_in,             // sync reset, high
  input  wire logic                    access_strobe_n_in, // host strobe, low
  input  wire logic                    dir_read_in,        // 1 read, 0 write
  input  wire logic [smhp_pkg::AW-1:0] addr_in,            // register select
  input  wire logic [smhp_pkg::DW-1:0] data_in,            // bus from host
  output logic      [smhp_pkg::DW-1:0] data_out,           // bus to host
  output logic                         data_oe_n_out,      // low drives bus
  output logic                         ready_out,          // low holds host
  input  wire smhp_pkg::smhp_core_s    core_in,            // engine events
  output smhp_pkg::smhp_ctrl_s         ctrl_out            // engine controls
);

  if (LEAD_MAX < 1 || LEAD_MAX > 7) begin : g_bad_lead
    $error("LEAD_MAX must be 1..7");
  end

  localparam logic [smhp_pkg::LEAD_W-1:0] LEAD_TOP = smhp_pkg::LEAD_W'(LEAD_MAX);

  // enum literals live in the package and nothing is imported
  localparam smhp_pkg::smhp_state_e SMHP_IDLE = smhp_pkg::SMHP_IDLE;
  localparam smhp_pkg::smhp_state_e SMHP_WAIT = smhp_pkg::SMHP_WAIT;
  localparam smhp_pkg::smhp_state_e SMHP_DONE = smhp_pkg::SMHP_DONE;

  typedef struct packed {
    smhp_pkg::smhp_state_e       state;
    logic                        stb_hi;
    logic                        dir_read;
    logic [smhp_pkg::AW-1:0]     addr;
    logic                        rise_seen;
    logic [smhp_pkg::DW-1:0]     wdata;
    logic [smhp_pkg::DW-1:0]     rdata;
    logic                        oe_n;
    logic [smhp_pkg::DW-1:0]     setup_a;
    logic [smhp_pkg::DW-1:0]     setup_b;
    logic [smhp_pkg::DW-1:0]     op_request;
    logic [smhp_pkg::DW-1:0]     out_byte;
    logic                        out_valid;
    logic [smhp_pkg::DW-1:0]     in_byte;
    logic                        in_valid;
    logic [smhp_pkg::DW-1:0]     cycle_count;
    logic [smhp_pkg::DW-1:0]     pin_drive;
    logic [smhp_pkg::LEAD_W-1:0] lead;
    logic                        soft_reset;
  } smhp_port_s;

  smhp_port_s          st;
  smhp_port_s          next_st;
  smhp_pkg::smhp_pins_s pins;
  logic                stall;
  logic                busy;
  logic                ahead;
  logic                in_empty;
  logic                out_full;
  logic                strobe_low;
  logic [smhp_pkg::DW-1:0] wd;
  logic [smhp_pkg::DW-1:0] flags;
  logic [smhp_pkg::DW-1:0] rd_mux;

  // ************************************************************
  // pin crossing
  // ************************************************************
  // every pin gets the same latency, so address and data line up with strobe
  smhp_sync #(
    .W       (smhp_pkg::PIN_W),
    .RST_VAL (smhp_pkg::PIN_RST)
  ) u_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .async_in  ({access_strobe_n_in, dir_read_in, addr_in, data_in}),
    .level_out (pins)
  );

  assign strobe_low = !pins.access_strobe_n;

  // ************************************************************
  // visible status
  // ************************************************************
  assign busy     = |st.op_request[smhp_pkg::OPCODE_MSB:0];
  assign in_empty = !st.in_valid;
  assign out_full = st.out_valid || core_in.out_reset;
  assign ahead    = core_in.full_duplex && (|st.setup_b[smhp_pkg::RDLY_MSB:0]) && (st.lead >= LEAD_TOP);

  always_comb begin
    flags = {{(smhp_pkg::DW - smhp_pkg::CORE_STATE_W){1'b0}}, core_in.state_bits};
    flags[smhp_pkg::FLAG_RSVD_BIT]  = 1'b0;
    flags[smhp_pkg::FLAG_EMPTY_BIT] = in_empty;
    flags[smhp_pkg::FLAG_FULL_BIT]  = out_full;
  end

  always_comb begin
    case (st.addr)
      smhp_pkg::ADDR_SETUP_A: rd_mux = st.setup_a;
      smhp_pkg::ADDR_SETUP_B: rd_mux = st.setup_b;
      smhp_pkg::ADDR_FLAGS:   rd_mux = flags;
      smhp_pkg::ADDR_OPREQ:   rd_mux = st.op_request;
      smhp_pkg::ADDR_OUTBUF:  rd_mux = st.out_byte;
      smhp_pkg::ADDR_INBUF:   rd_mux = st.in_byte;
      smhp_pkg::ADDR_COUNT:   rd_mux = st.cycle_count;
      smhp_pkg::ADDR_PINS:    rd_mux = st.pin_drive;
      default:                rd_mux = smhp_pkg::REG_RST;
    endcase
  end

  // stall checks the live bus byte until the rising strobe freezes it
  assign wd = st.rise_seen ? st.wdata : pins.data;

  smhp_stall u_stall (
    .addr_in     (st.addr),
    .read_in     (st.dir_read),
    .wdata_in    (wd),
    .in_empty_in (in_empty),
    .out_full_in (out_full),
    .busy_in     (busy),
    .ahead_in    (ahead),
    .stall_out   (stall)
  );

  // ************************************************************
  // access sequencer and registers
  // ************************************************************
  always_comb begin
    next_st            = st;
    next_st.stb_hi     = pins.access_strobe_n;
    next_st.soft_reset = 1'b0;
    next_st.oe_n       = !(strobe_low && pins.dir_read);
    // engine side first so that a host access in the same cycle wins
    if (core_in.in_push) begin
      next_st.in_valid = 1'b1;
      next_st.in_byte  = core_in.in_byte;
    end
    if (core_in.out_pop) begin
      next_st.out_valid = 1'b0;
    end
    if (core_in.cmd_done) begin
      next_st.op_request[smhp_pkg::OPCODE_MSB:0] = '0;
    end
    if (!core_in.full_duplex) begin
      next_st.lead = smhp_pkg::LEAD_ZERO;
    end
    case (st.state)
      SMHP_IDLE: begin
        if (st.stb_hi && strobe_low) begin
          // direction and address are steady from here until strobe rises
          next_st.addr      = pins.addr;
          next_st.dir_read  = pins.dir_read;
          next_st.rise_seen = 1'b0;
          next_st.state     = SMHP_WAIT;
        end
      end
      SMHP_WAIT: begin
        if (st.dir_read) begin
          if (!strobe_low) begin
            next_st.state = SMHP_IDLE;
          end else if (!stall) begin
            next_st.rdata = rd_mux;
            if (st.addr == smhp_pkg::ADDR_INBUF) begin
              next_st.in_valid = core_in.in_push;
              if (st.lead != smhp_pkg::LEAD_ZERO && core_in.full_duplex) begin
                next_st.lead = st.lead - smhp_pkg::LEAD_ONE;
              end
            end
            next_st.state = SMHP_DONE;
          end
        end else begin
          if (!strobe_low && !st.rise_seen) begin
            next_st.wdata     = pins.data;
            next_st.rise_seen = 1'b1;
          end
          // a held-off write lands once its block clears and the strobe is seen high
          if (!strobe_low && !stall) begin
            next_st.state = SMHP_IDLE;
            case (st.addr)
              smhp_pkg::ADDR_SETUP_A: next_st.setup_a = wd;
              smhp_pkg::ADDR_SETUP_B: next_st.setup_b = wd;
              smhp_pkg::ADDR_COUNT:   next_st.cycle_count = wd;
              smhp_pkg::ADDR_PINS: begin
                if (!busy) begin
                  next_st.pin_drive = wd;
                end
              end
              smhp_pkg::ADDR_OPREQ: begin
                if (wd[smhp_pkg::SRST_BIT]) begin
                  next_st.op_request = smhp_pkg::REG_RST;
                  next_st.in_valid   = 1'b0;
                  next_st.out_valid  = 1'b0;
                  next_st.lead       = smhp_pkg::LEAD_ZERO;
                  next_st.soft_reset = 1'b1;
                end else begin
                  next_st.op_request = wd;
                end
              end
              smhp_pkg::ADDR_OUTBUF: begin
                next_st.out_byte  = wd;
                next_st.out_valid = 1'b1;
                if (core_in.full_duplex && (|st.setup_b[smhp_pkg::RDLY_MSB:0])) begin
                  next_st.lead = st.lead + smhp_pkg::LEAD_ONE;
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      SMHP_DONE: begin
        if (!strobe_low) begin
          next_st.state = SMHP_IDLE;
        end
      end
      default: next_st.state = SMHP_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st            <= '0;
      st.state      <= SMHP_IDLE;
      st.stb_hi     <= 1'b1;
      st.oe_n       <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign data_out      = st.rdata;
  assign data_oe_n_out = st.oe_n;
  assign ready_out     = !((st.state == SMHP_WAIT) && stall);

  assign ctrl_out.setup_a     = st.setup_a;
  assign ctrl_out.setup_b     = st.setup_b;
  assign ctrl_out.op_request  = st.op_request;
  assign ctrl_out.cycle_count = st.cycle_count;
  assign ctrl_out.pin_drive   = st.pin_drive;
  assign ctrl_out.out_byte    = st.out_byte;
  assign ctrl_out.out_valid   = st.out_valid;
  assign ctrl_out.soft_reset  = st.soft_reset;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_wr_commit;
    st.state == SMHP_WAIT && !st.dir_read && !strobe_low && !stall;
  endsequence

  sequence s_rd_grant;
    st.state == SMHP_WAIT && st.dir_read && strobe_low && !stall;
  endsequence

  property p_float_high;
    !strobe_low |=> data_oe_n_out;
  endproperty
  a_float_high: assert property (p_float_high) else $error("bus driven while strobe high");

  property p_write_float;
    (strobe_low && !pins.dir_read) |=> data_oe_n_out;
  endproperty
  a_write_float: assert property (p_write_float) else $error("bus driven during write");

  property p_in_empty_stall;
    (st.state == SMHP_WAIT && st.dir_read && st.addr == smhp_pkg::ADDR_INBUF && !st.in_valid) |-> !ready_out;
  endproperty
  a_in_empty_stall: assert property (p_in_empty_stall) else $error("empty inbound read not held");

  property p_out_full_stall;
    (st.state == SMHP_WAIT && !st.dir_read && st.addr == smhp_pkg::ADDR_OUTBUF && out_full) |-> !ready_out;
  endproperty
  a_out_full_stall: assert property (p_out_full_stall) else $error("full outbound write not held");

  property p_busy_stall;
    (st.state == SMHP_WAIT && !st.dir_read && busy && st.addr == smhp_pkg::ADDR_COUNT) |-> !ready_out;
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("count write during command not held");

  property p_srst_free;
    (st.state == SMHP_WAIT && !st.dir_read && st.addr == smhp_pkg::ADDR_OPREQ && wd[smhp_pkg::SRST_BIT])
      |-> ready_out;
  endproperty
  a_srst_free: assert property (p_srst_free) else $error("soft reset write stalled");

  property p_lead_cap;
    st.lead <= LEAD_TOP;
  endproperty
  a_lead_cap: assert property (p_lead_cap) else $error("write-ahead beyond limit");

  property p_count_write;
    (s_wr_commit and (st.addr == smhp_pkg::ADDR_COUNT)) |=> st.cycle_count == $past(wd) && st.state == SMHP_IDLE;
  endproperty
  a_count_write: assert property (p_count_write) else $error("count byte not stored at strobe rise");

  property p_read_data;
    s_rd_grant |=> data_out == $past(rd_mux) ##1 st.state != SMHP_WAIT;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not presented");

  property p_flag_rsvd;
    st.state == SMHP_DONE && st.addr == smhp_pkg::ADDR_FLAGS |-> !data_out[smhp_pkg::FLAG_RSVD_BIT];
  endproperty
  a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flag bit reads one");

endmodule // smhp_host_port

// >>> smhp_pkg.sv
// shared constants, types and carriers of the scan master host port
package smhp_pkg;

  // ************************************************************
  // widths and register map
  // ************************************************************
  localparam int DW = 8;
  localparam int AW = 3;
  localparam logic [AW-1:0] ADDR_SETUP_A = 3'h0;
  localparam logic [AW-1:0] ADDR_SETUP_B = 3'h1;
  localparam logic [AW-1:0] ADDR_FLAGS   = 3'h2;
  localparam logic [AW-1:0] ADDR_OPREQ   = 3'h3;
  localparam logic [AW-1:0] ADDR_OUTBUF  = 3'h4;
  localparam logic [AW-1:0] ADDR_INBUF   = 3'h5;
  localparam logic [AW-1:0] ADDR_COUNT   = 3'h6;
  localparam logic [AW-1:0] ADDR_PINS    = 3'h7;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int FLAG_EMPTY_BIT = 7;
  localparam int FLAG_FULL_BIT  = 6;
  localparam int FLAG_RSVD_BIT  = 4;
  localparam int CORE_STATE_W   = 6;
  localparam int SRST_BIT       = 7;
  localparam int OPCODE_MSB     = 3;
  localparam int RDLY_MSB       = 3;
  localparam int LEAD_LIMIT     = 5;
  localparam int LEAD_W         = 3;
  localparam logic [DW-1:0]     REG_RST   = 8'h00;
  localparam logic [LEAD_W-1:0] LEAD_ZERO = 3'h0;
  localparam logic [LEAD_W-1:0] LEAD_ONE  = 3'h1;

  // pin bundle as sampled: strobe (active low), read select, address, data
  localparam int PIN_W = 1 + 1 + AW + DW;
  localparam logic [PIN_W-1:0] PIN_RST = 13'h1000;

  typedef enum logic [2:0] {
    SMHP_IDLE = 3'b001,
    SMHP_WAIT = 3'b010,
    SMHP_DONE = 3'b100
  } smhp_state_e;

  typedef struct packed {
    logic          access_strobe_n;
    logic          dir_read;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } smhp_pins_s;

  // from the scan engine into the port
  typedef struct packed {
    logic                    in_push;
    logic [DW-1:0]           in_byte;
    logic                    out_pop;
    logic                    out_reset;
    logic                    cmd_done;
    logic                    full_duplex;
    logic [CORE_STATE_W-1:0] state_bits;
  } smhp_core_s;

  // from the port to the scan engine
  typedef struct packed {
    logic [DW-1:0] setup_a;
    logic [DW-1:0] setup_b;
    logic [DW-1:0] op_request;
    logic [DW-1:0] cycle_count;
    logic [DW-1:0] pin_drive;
    logic [DW-1:0] out_byte;
    logic          out_valid;
    logic          soft_reset;
  } smhp_ctrl_s;

endpackage

// >>> smhp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module smhp_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         mclk_in,   // core clock
  input  wire logic         rst_in,    // sync reset, high
  input  wire logic [W-1:0] async_in,  // raw pins
  output logic      [W-1:0] level_out  // filtered level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } smhp_sync_s;

  smhp_sync_s st;
  smhp_sync_s next_st;

  // ************************************************************
  // stages
  // ************************************************************
  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a bit moves only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.lvl;

endmodule // smhp_sync

// >>> smhp_stall.sv
// decides whether the pending host access must wait
`timescale 1ns/1ps
module smhp_stall (
  input  wire logic [smhp_pkg::AW-1:0] addr_in,      // latched address
  input  wire logic                    read_in,      // access is a read
  input  wire logic [smhp_pkg::DW-1:0] wdata_in,     // write byte
  input  wire logic                    in_empty_in,  // inbound empty
  input  wire logic                    out_full_in,  // outbound full/reset
  input  wire logic                    busy_in,      // command running
  input  wire logic                    ahead_in,     // write-ahead at limit
  output logic                         stall_out     // hold ready low
);

  // ************************************************************
  // blocking conditions
  // ************************************************************
  always_comb begin
    stall_out = 1'b0;
    if (read_in) begin
      stall_out = (addr_in == smhp_pkg::ADDR_INBUF) && in_empty_in;
    end else begin
      case (addr_in)
        smhp_pkg::ADDR_OUTBUF: stall_out = out_full_in || ahead_in;
        smhp_pkg::ADDR_SETUP_A,
        smhp_pkg::ADDR_SETUP_B,
        smhp_pkg::ADDR_COUNT:  stall_out = busy_in;
        // a soft reset request always goes through
        smhp_pkg::ADDR_OPREQ:  stall_out = busy_in && !wdata_in[smhp_pkg::SRST_BIT];
        default:               stall_out = 1'b0;
      endcase
    end
  end

endmodule // smhp_stall

// >>> smhp_host_model.sv
// host processor model driving the strobe-timed register bus
`timescale 1ns/1ps
module smhp_host_model (
  input  wire logic                    mclk_in,      // core clock
  input  wire logic                    ready_in,     // device ready
  input  wire logic [smhp_pkg::DW-1:0] bus_in,       // resolved data bus
  output logic                         strobe_n_out, // access strobe, low
  output logic                         dir_read_out, // 1 read, 0 write
  output logic      [smhp_pkg::AW-1:0] addr_out,     // register select
  output logic      [smhp_pkg::DW-1:0] data_out,     // write byte
  output logic                         drive_out,    // host drives bus
  output logic                         done_out,     // read finished
  output logic      [smhp_pkg::DW-1:0] rdata_out     // byte read
);
  initial begin
    strobe_n_out = 1'b1;
    dir_read_out = 1'b1;
    addr_out     = '0;
    data_out     = '0;
    drive_out    = 1'b0;
    done_out     = 1'b0;
    rdata_out    = '0;
  end

  // ************************************************************
  // one strobe cycle, held low until ready
  // ************************************************************
  task automatic access(input logic rd, input logic [smhp_pkg::AW-1:0] a, input logic [smhp_pkg::DW-1:0] d);
    logic [smhp_pkg::DW-1:0] q;
    @(negedge mclk_in);
    dir_read_out = rd;
    addr_out     = a;
    data_out     = d;
    drive_out    = !rd;
    strobe_n_out = 1'b0;
    // ready and bus looked at on falling edges, where they have settled
    repeat (8) @(negedge mclk_in);
    // no limit here: a hang runs into the bench's cycle ceiling
    while (ready_in !== 1'b1) begin
      @(negedge mclk_in);
    end
    // grant and read data land a few edges after ready
    repeat (3) @(negedge mclk_in);
    q = bus_in;
    strobe_n_out = 1'b1;
    done_out     = rd;
    rdata_out    = q;
    @(negedge mclk_in);
    done_out = 1'b0;
    // write byte kept on the bus past the synced rise
    repeat (8) @(negedge mclk_in);
    drive_out = 1'b0;
  endtask
endmodule // smhp_host_model

// >>> smhp_host_port_tb.sv
// self-checking bench of the scan master host port
`timescale 1ns/1ps
module smhp_host_port_tb;
  localparam int LEAD = 5;
  logic                    mclk_in = 1'b0;
  logic                    rst_in  = 1'b1;
  logic                    strobe_n, dir_rd, hdrv, done, oe_n, rdy;
  logic [smhp_pkg::AW-1:0] addr;
  logic [smhp_pkg::DW-1:0] hdata, dout, rdata, v, pv;
  wire  [smhp_pkg::DW-1:0] bus;
  smhp_pkg::smhp_core_s    core;
  smhp_pkg::smhp_ctrl_s    ctrl;
  logic [smhp_pkg::DW-1:0] expq[$];
  logic [smhp_pkg::DW-1:0] mask[8] = '{8'h21, 8'h8F, 8'h00, 8'h70, 8'hFF, 8'h00, 8'hFF, 8'h0F};
  int                      n_mismatch = 0;
  int                      n_tests = 0;
  int                      cyc = 0;
  int                      srcnt = 0;
  int                      nlow = 0;
  int                      low0 = 0;

  always #2.5 mclk_in = ~mclk_in;
  // a released bus toggles so a missing drive never passes as data
  assign bus = !oe_n ? dout : (hdrv ? hdata : ({8{mclk_in}} ^ 8'h5A));

  smhp_host_port #(.LEAD_MAX(LEAD)) u_smhp_host_port (
    .mclk_in(mclk_in), .rst_in(rst_in), .access_strobe_n_in(strobe_n), .dir_read_in(dir_rd), .addr_in(addr),
    .data_in(bus), .data_out(dout), .data_oe_n_out(oe_n), .ready_out(rdy), .core_in(core), .ctrl_out(ctrl));
  smhp_host_model u_smhp_host_model (
    .mclk_in(mclk_in), .ready_in(rdy), .bus_in(bus), .strobe_n_out(strobe_n), .dir_read_out(dir_rd),
    .addr_out(addr), .data_out(hdata), .drive_out(hdrv), .done_out(done), .rdata_out(rdata));

  // ************************************************************
  // checking, closing and access tasks
  // ************************************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_smhp_host_model.access(1'b0, a, d);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] d);
    expq.push_back(d);
    u_smhp_host_model.access(1'b1, a, 8'h00);
  endtask

  // engine event: 0 push, 1 pop, 2 end of reset, 3 command done, 4 leave full duplex
  task automatic evt(input int kind, input logic [7:0] d);
    @(negedge mclk_in);
    core.in_push  = (kind == 0);
    core.in_byte  = d;
    core.out_pop  = (kind == 1);
    core.cmd_done = (kind == 3);
    if (kind == 2) core.out_reset = 1'b0;
    if (kind == 4) core.full_duplex = 1'b0;
    @(negedge mclk_in);
    core.in_push  = 1'b0;
    core.out_pop  = 1'b0;
    core.cmd_done = 1'b0;
  endtask

  task automatic stall(input logic r, input logic [2:0] a, input logic [7:0] d, input int kind);
    fork
      if (r) rd(a, d);
      else wr(a, d);
      begin
        repeat (30) @(negedge mclk_in);
        check("ready", {7'h0, rdy}, 8'h00);
        evt(kind, d);
      end
    join
  endtask

  always @(posedge mclk_in) if (done === 1'b1) check("read data", rdata, expq.pop_front());
  always @(negedge mclk_in) if (dir_rd === 1'b0 && !rst_in) check("oe_n", {7'h0, oe_n}, 8'h01);
  always @(posedge mclk_in) if (rdy === 1'b0) nlow++;
  always @(posedge mclk_in) if (ctrl.soft_reset === 1'b1) srcnt++;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    core            = '0;
    core.state_bits = 6'h3F;
    void'($urandom(32'hAE319A25));
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      if (i != 2 && i != 4 && i != 5) begin
        v = 8'($urandom) & mask[i];
        if (i == 7) pv = v;
        wr(3'(i), v);
        rd(3'(i), v);
      end
    end
    v = 8'($urandom);
    wr(3'h4, v);
    rd(3'h4, v);
    rd(3'h2, 8'hEF);
    stall(1'b0, 3'h4, ~v, 1);
    rd(3'h4, ~v);
    evt(1, 8'h00);
    core.out_reset = 1'b1;
    stall(1'b0, 3'h4, v, 2);
    evt(1, 8'h00);
    wr(3'h2, 8'($urandom));
    wr(3'h5, v);
    rd(3'h2, 8'hAF);
    evt(0, v);
    rd(3'h2, 8'h2F);
    rd(3'h5, v);
    stall(1'b1, 3'h5, ~v, 0);
    for (int i = 0; i < 7; i++) begin
      if (i == 0 || i == 1 || i == 3 || i == 6) begin
        v = 8'($urandom) & mask[i];
        wr(3'h3, 8'h01);
        stall(1'b0, 3'(i), v, 3);
        rd(3'(i), v);
      end
    end
    check("count copy", ctrl.cycle_count, v);
    wr(3'h3, 8'h01);
    wr(3'h7, ~pv & 8'h0F);
    rd(3'h7, pv);
    check("pin copy", ctrl.pin_drive, pv);
    rd(3'h3, 8'h01);
    low0 = nlow;
    wr(3'h3, 8'h80);
    check("ready low seen", {7'h0, (nlow != low0)}, 8'h00);
    check("soft reset pulses", 8'(srcnt), 8'h01);
    rd(3'h3, 8'h00);
    wr(3'h1, 8'h01);
    core.full_duplex = 1'b1;
    low0             = nlow;
    for (int i = 0; i < LEAD; i++) begin
      wr(3'h4, 8'(i));
      evt(1, 8'h00);
    end
    check("ready low seen", {7'h0, (nlow != low0)}, 8'h00);
    stall(1'b0, 3'h4, 8'h3C, 4);
    check("outbound copy", ctrl.out_byte, 8'h3C);
    check("outbound valid", {7'h0, ctrl.out_valid}, 8'h01);
    finish_test();
  end
endmodule // smhp_host_port_tb
